// ==== logic/pftreg_bank.v ====
// Purpose: Platform-time monitor, spread PLL and enable-pin register group
// Assumes: Serial-bus engine gives byte address, write strobe and read strobe
// Notes: Read data appears one cycle after the read strobe
// Function
// - Bit 7 of control shows live lost level
// - Freeze bit holds both delta registers
// - Clear bit forces both delta registers zero
// - Delta is signed, 0.763 ppm per step
// - Low delta byte holds bits 7:0, read-only
// - High byte holds bits 14:8 plus sign bit
// - Spread bits 5:4 show live spread pins
// - Bit 3 picks crystal or filter PLL source
// - Bit 2 hands spread control from pins
// - Spread select latches pins at power-up
// - Filter PLL source drops output synchronisation guarantee
// - Enable-pin readback bits 6:0 live, bit 7 zero
// - Byte access by serial-bus block transfers
// - Mux select low means 100MHz selectable outputs
`include "pftreg_consts.vh"

module pftreg_bank #(
  parameter DELTA_W = `PFTREG_DELTA_W,
  parameter ENPIN_W = `PFTREG_ENPIN_W
) (
  // Clock and reset
  input wire i_clock,
  input wire i_reset,
  // Byte register port from the serial-bus engine
  input wire [7:0] i_reg_addr,
  input wire i_reg_write,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_read,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_rvalid,
  // Platform-time monitor
  input wire i_platform_time_lost_indicator,
  input wire [DELTA_W-1:0] i_delta_measure,
  input wire i_delta_measure_valid,
  // Spread spectrum pins and frequency select
  input wire [1:0] i_spread_pins,
  input wire i_mux_frequency_select,
  // Active-low output-enable pins
  input wire [ENPIN_W-1:0] i_enable_pins_n,
  // Spread PLL controls to the analog core
  output wire [1:0] o_spread_amount,
  output wire o_spread_source_filter,
  output wire o_outputs_sync_guaranteed,
  output wire o_selectable_100m
);

  // Writable control bits
  reg freeze_delta_update_reg; // Holds the delta registers
  reg delta_clear_reg; // Forces delta registers to zero
  reg spread_source_filter_reg; // 0 crystal, 1 filter PLL
  reg spread_pin_control_off_reg; // 1 means register governs spread
  reg [1:0] spread_amount_select_reg; // Register spread amount
  reg latch_pending_reg; // One-shot pin latch after reset

  // Held delta from the measurement path
  wire [DELTA_W-1:0] delta_value;
  // Decoded write strobes
  wire wr_pt_ctrl;
  wire wr_spread;
  // Assembled read bytes
  wire [7:0] pt_ctrl_byte;
  wire [7:0] delta_lo_byte;
  wire [7:0] delta_hi_byte;
  wire [7:0] spread_byte;
  wire [7:0] enpin_byte;
  // Read mux output
  reg [7:0] read_mux;
  // Pin readback vector, one bit per active-low pin
  wire [ENPIN_W-1:0] enpin_live;

  // Address decode for writable bytes; other locations drop writes
  assign wr_pt_ctrl = i_reg_write && (i_reg_addr == `PFTREG_OFS_PT_CTRL);
  assign wr_spread = i_reg_write && (i_reg_addr == `PFTREG_OFS_SPREAD);

  // Platform-time control bits; only bits 6 and 5 take writes
  always @(posedge i_clock) begin
    if (i_reset) begin
      freeze_delta_update_reg <= `PFTREG_BIT_RESET;
      delta_clear_reg <= `PFTREG_BIT_RESET;
    end else if (wr_pt_ctrl) begin
      // Bit 7 and reserved bits are discarded
      freeze_delta_update_reg <= i_reg_wdata[`PFTREG_PT_FREEZE_BIT];
      delta_clear_reg <= i_reg_wdata[`PFTREG_PT_CLEAR_BIT];
    end
  end

  // Spread control bits and the power-up pin latch
  always @(posedge i_clock) begin
    if (i_reset) begin
      spread_source_filter_reg <= `PFTREG_BIT_RESET;
      spread_pin_control_off_reg <= `PFTREG_BIT_RESET;
      spread_amount_select_reg <= `PFTREG_SPREAD_OFF;
      latch_pending_reg <= 1'b1;
    end else begin
      latch_pending_reg <= 1'b0;
      if (latch_pending_reg) begin
        // First cycle after release captures the strap pins
        spread_amount_select_reg <= i_spread_pins;
      end
      if (wr_spread) begin
        // Readback and reserved bits are discarded
        spread_source_filter_reg <= i_reg_wdata[`PFTREG_SP_SOURCE_BIT];
        spread_pin_control_off_reg <= i_reg_wdata[`PFTREG_SP_PINCTL_BIT];
        spread_amount_select_reg <=
          i_reg_wdata[`PFTREG_SP_SEL_HI:`PFTREG_SP_SEL_LO];
      end
    end
  end

  // Delta holding register with freeze and clear
  pftreg_delta #(
    .WIDTH(DELTA_W)
  ) u_delta (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_measure(i_delta_measure),
    .i_measure_valid(i_delta_measure_valid),
    .i_freeze(freeze_delta_update_reg),
    .i_clear(delta_clear_reg),
    .o_delta(delta_value)
  );

  // Control byte: live lost level, then the two control bits
  assign pt_ctrl_byte = {
    i_platform_time_lost_indicator,
    freeze_delta_update_reg,
    delta_clear_reg,
    5'h00 // Reserved reads zero
  };

  // Low delta byte: two's-complement delta bits 7:0
  assign delta_lo_byte = delta_value[7:0];

  // High delta byte: sign in bit 7, bits 14:8 below it
  assign delta_hi_byte = {
    delta_value[`PFTREG_DELTA_SIGN_BIT],
    delta_value[`PFTREG_DELTA_TOP_BIT:8]
  };

  // Spread byte: live pins, source, pin control, select
  assign spread_byte = {
    2'h0, // Reserved reads zero
    i_spread_pins,
    spread_source_filter_reg,
    spread_pin_control_off_reg,
    spread_amount_select_reg
  };

  // Enable-pin readback: pin level per bit, as sampled this cycle
  genvar g;
  generate
    for (g = 0; g < ENPIN_W; g = g + 1) begin : g_enpin
      assign enpin_live[g] = i_enable_pins_n[g];
    end
  endgenerate

  // Bit 7 is reserved and reads zero
  assign enpin_byte = {1'b0, enpin_live};

  // Read mux; unmapped locations return zero
  always @* begin
    case (i_reg_addr)
      `PFTREG_OFS_PT_CTRL: begin
        read_mux = pt_ctrl_byte;
      end
      `PFTREG_OFS_DELTA_LO: begin
        read_mux = delta_lo_byte;
      end
      `PFTREG_OFS_DELTA_HI: begin
        read_mux = delta_hi_byte;
      end
      `PFTREG_OFS_SPREAD: begin
        read_mux = spread_byte;
      end
      `PFTREG_OFS_ENPIN: begin
        read_mux = enpin_byte;
      end
      default: begin
        read_mux = `PFTREG_BYTE_ZERO;
      end
    endcase
  end

  // Registered read data; each byte stands alone so a stop after any byte is safe
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_reg_rdata <= `PFTREG_BYTE_ZERO;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_read;
      if (i_reg_read) begin
        o_reg_rdata <= read_mux;
      end
    end
  end

  // Effective spread: pins govern unless register control is chosen
  // Spread applies only while selectable outputs run at 100MHz
  assign o_spread_amount = i_mux_frequency_select ? `PFTREG_SPREAD_OFF :
    (spread_pin_control_off_reg ? spread_amount_select_reg : i_spread_pins);

  // Source selection for the spread PLL
  assign o_spread_source_filter = spread_source_filter_reg;

  // Filter PLL source gives no phase-alignment promise
  assign o_outputs_sync_guaranteed = ~spread_source_filter_reg;

  // Selectable outputs at 100MHz when the mux select is low
  assign o_selectable_100m = ~i_mux_frequency_select;

endmodule

// ==== logic/pftreg_consts.vh ====
// Purpose: Shared constants for the platform-time and spread register group
// Assumes: Byte-wide register port driven by an external serial-bus engine
// Notes: Offsets are byte locations as seen by the serial-bus host
`ifndef PFTREG_CONSTS_VH
`define PFTREG_CONSTS_VH

// Register byte locations
`define PFTREG_OFS_PT_CTRL 8'h03
`define PFTREG_OFS_DELTA_LO 8'h04
`define PFTREG_OFS_DELTA_HI 8'h05
`define PFTREG_OFS_SPREAD 8'h06
`define PFTREG_OFS_ENPIN 8'h07

// Platform-time control field positions
`define PFTREG_PT_LOST_BIT 7
`define PFTREG_PT_FREEZE_BIT 6
`define PFTREG_PT_CLEAR_BIT 5

// Spread control field positions
`define PFTREG_SP_PIN_HI 5
`define PFTREG_SP_PIN_LO 4
`define PFTREG_SP_SOURCE_BIT 3
`define PFTREG_SP_PINCTL_BIT 2
`define PFTREG_SP_SEL_HI 1
`define PFTREG_SP_SEL_LO 0

// Frequency-delta layout
`define PFTREG_DELTA_W 16
`define PFTREG_DELTA_SIGN_BIT 15
`define PFTREG_DELTA_TOP_BIT 14

// Spread amount encodings
`define PFTREG_SPREAD_OFF 2'h0
`define PFTREG_SPREAD_03 2'h1
`define PFTREG_SPREAD_RSVD 2'h2
`define PFTREG_SPREAD_05 2'h3

// Reset values, fill patterns and enable-pin width
`define PFTREG_BIT_RESET 1'h0
`define PFTREG_BYTE_ZERO 8'h00
`define PFTREG_DELTA_ZERO 16'h0000
`define PFTREG_ENPIN_W 7

`endif

// ==== logic/pftreg_delta.v ====
// Purpose: Holding register for the signed platform-time frequency delta
// Assumes: A measurement engine presents a 16-bit two's-complement delta
// Notes: Clear forces zero and beats freeze; freeze holds the last value
`include "pftreg_consts.vh"

module pftreg_delta #(
  parameter WIDTH = `PFTREG_DELTA_W
) (
  // Clock and reset
  input wire i_clock,
  input wire i_reset,
  // Measurement input
  input wire [WIDTH-1:0] i_measure,
  input wire i_measure_valid,
  // Controls from the platform-time control register
  input wire i_freeze,
  input wire i_clear,
  // Held delta
  output wire [WIDTH-1:0] o_delta
);

  // Held delta value and its next state
  reg [WIDTH-1:0] delta_reg;
  reg [WIDTH-1:0] delta_next;

  // Clear wins, then freeze holds, else each new sample loads
  always @* begin
    delta_next = delta_reg;
    if (i_clear) begin
      delta_next = {WIDTH{1'b0}};
    end else if (i_freeze) begin
      delta_next = delta_reg;
    end else if (i_measure_valid) begin
      delta_next = i_measure;
    end
  end

  // State update
  always @(posedge i_clock) begin
    if (i_reset) begin
      delta_reg <= {WIDTH{1'b0}};
    end else begin
      delta_reg <= delta_next;
    end
  end

  assign o_delta = delta_reg;

endmodule

// ==== tb/pftreg_host.sv ====
// Purpose: Byte-level host that reaches the register group
// Assumes: One request at a time, each strobe held for one edge
// Notes: Idle address and data show the inverse of the last value
module pftreg_host (
  input logic i_clock,
  input logic [7:0] i_rdata,
  input logic i_rvalid,
  output logic [7:0] o_addr = 8'h00,
  output logic o_write = 1'b0,
  output logic [7:0] o_wdata = 8'h00,
  output logic o_read = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // One whole byte written, then released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= d;
    o_write <= 1'b1;
    @(posedge i_clock);
    o_write <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // One byte read; the strobe is a one-edge pulse, address stays until the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_read <= 1'b1;
    @(posedge i_clock);
    // Strobe taken at this edge; valid is launched here, so wait one more edge
    o_read <= 1'b0;
    @(posedge i_clock);
    // Valid and data stand before this edge's updates land
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
    o_addr <= ~a;
  endtask
endmodule

// ==== tb/pftreg_bank_props.sv ====
// Purpose: Port checks for the register group
// Assumes: Reads answer one cycle after the strobe
// Notes: Bound to every instance of the bank
module pftreg_bank_props (
  input logic i_clock,
  input logic i_reset,
  input logic [7:0] i_reg_addr,
  input logic i_reg_read,
  input logic [7:0] o_reg_rdata,
  input logic o_reg_rvalid,
  input logic i_platform_time_lost_indicator,
  input logic [1:0] i_spread_pins,
  input logic i_mux_frequency_select,
  input logic [6:0] i_enable_pins_n,
  input logic [1:0] o_spread_amount,
  input logic o_spread_source_filter,
  input logic o_outputs_sync_guaranteed,
  input logic o_selectable_100m
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  read_answer_a: assert property (i_reg_read |=> o_reg_rvalid)
    else $error("read not answered");
  idle_quiet_a: assert property (o_reg_rvalid |-> $past(i_reg_read))
    else $error("valid without read");
  lost_live_a: assert property (i_reg_read && i_reg_addr == 8'h03 |=>
    o_reg_rdata[7] == $past(i_platform_time_lost_indicator) && o_reg_rdata[4:0] == 5'h00)
    else $error("lost bit or reserved wrong");
  pin_echo_a: assert property (i_reg_read && i_reg_addr == 8'h06 |=>
    o_reg_rdata[7:4] == {2'h0, $past(i_spread_pins)})
    else $error("spread pin readback wrong");
  enable_echo_a: assert property (i_reg_read && i_reg_addr == 8'h07 |=>
    o_reg_rdata == {1'b0, $past(i_enable_pins_n)})
    else $error("enable pin readback wrong");
  unmapped_zero_a: assert property (i_reg_read && i_reg_addr > 8'h07 |=>
    o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  mux_select_a: assert property (o_selectable_100m != i_mux_frequency_select)
    else $error("frequency select wrong");
  sync_guard_a: assert property (o_outputs_sync_guaranteed != o_spread_source_filter)
    else $error("sync flag wrong");
  spread_off_a: assert property (i_mux_frequency_select |-> o_spread_amount == 2'h0)
    else $error("spread not off");
endmodule
bind pftreg_bank pftreg_bank_props pftreg_bank_props_i (.*);

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the register group
// Assumes: Host model issues byte reads and writes
// Notes: Random values come from a fixed xorshift seed
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, lost = 1'b0, dv = 1'b0, mux = 1'b0;
  logic [15:0] dm = 16'h0000, held = 16'h0000;
  logic [1:0] sp = 2'h3, amt;
  logic [6:0] oe = 7'h00;
  logic [7:0] ad, wd, rdat, q;
  logic wr, rd, rv, src, syn, sel;
  logic [31:0] seed = 32'h0000000E, r;
  logic [3:0] c;
  int err_total = 0, comparisons = 0;
  pftreg_bank pftreg_bank_i (.i_clock(clk), .i_reset(rst), .i_reg_addr(ad),
    .i_reg_write(wr), .i_reg_wdata(wd), .i_reg_read(rd), .o_reg_rdata(rdat),
    .o_reg_rvalid(rv), .i_platform_time_lost_indicator(lost), .i_delta_measure(dm),
    .i_delta_measure_valid(dv), .i_spread_pins(sp), .i_mux_frequency_select(mux),
    .i_enable_pins_n(oe), .o_spread_amount(amt), .o_spread_source_filter(src),
    .o_outputs_sync_guaranteed(syn), .o_selectable_100m(sel));
  pftreg_host host_i (.i_clock(clk), .i_rdata(rdat), .i_rvalid(rv), .o_addr(ad),
    .o_write(wr), .o_wdata(wd), .o_read(rd));
  initial begin
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Spread register image: pins above the control nibble
  function automatic logic [7:0] sp_exp(input logic [1:0] p, input logic [3:0] k);
    return {2'h0, p, k};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_i.rd(a, q);
    chk(q, e);
  endtask
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    dm <= v;
    dv <= 1'b1;
    @(posedge clk);
    dv <= 1'b0;
  endtask
  task automatic complete_run();
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h06, sp_exp(2'h3, 4'h3));
    for (int i = 0; i < 8; i++) begin
      r = xs();
      c = {r[3:2], i[1:0]};
      host_i.wr(8'h06, {r[7:4], c});
      sp <= r[9:8];
      mux <= r[10];
      rchk(8'h06, sp_exp(r[9:8], c));
      chk({3'h0, sel, src, syn, amt}, {3'h0, !mux, c[3], !c[3],
        mux ? 2'h0 : (c[2] ? c[1:0] : sp)});
    end
    for (int i = 0; i < 6; i++) begin
      r = xs();
      held = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : r[15:0];
      pulse(held);
      rchk(8'h04, held[7:0]);
      rchk(8'h05, held[15:8]);
    end
    host_i.wr(8'h04, 8'hFF);
    rchk(8'h04, held[7:0]);
    // Freeze first and read the low half, then clear and read the high half
    lost <= r[20];
    host_i.wr(8'h03, 8'h5F);
    pulse(~held);
    rchk(8'h03, {r[20], 7'h40});
    rchk(8'h04, held[7:0]);
    host_i.wr(8'h03, 8'h60);
    rchk(8'h05, 8'h00);
    host_i.wr(8'h03, 8'h00);
    pulse(~held);
    rchk(8'h05, ~held[15:8]);
    host_i.wr(8'h03, 8'h20);
    rchk(8'h04, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      oe <= r[6:0];
      rchk(8'h07, {1'b0, r[6:0]});
    end
    rchk(8'h08, 8'h00);
    // Second reset latches a new strap value
    rst <= 1'b1;
    sp <= 2'h2;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h06, sp_exp(2'h2, 4'h2));
    complete_run();
  end
endmodule
